// ===== rtl/esl_pkg.sv
// shared constants, codes and state types of the serial position link
// assumes a 40 MHz system clock on both ends
`default_nettype none
package esl_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int CMD_BITS = 6;
  localparam int POS_BITS_DEF = 24;
  localparam int ADD_BITS = 16;
  localparam int MEM_BITS = 16;
  localparam int MEM_ADDR_W = 3;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_ADD_WORDS = 2;
  // 14.5 link clock pulses counted as half periods
  localparam int CAL_HALVES = 29;
  localparam int LINK_MIN_KHZ = 100;
  localparam int LINK_MAX_KHZ = 2000;
  localparam int LINK_COMP_MAX_KHZ = 16000;
  localparam int CAL_REF_CAP_KHZ = 8000;

  localparam logic [CMD_BITS-1:0] CMD_POS = 6'h07;
  localparam logic [CMD_BITS-1:0] CMD_POS_AD1 = 6'h38;
  localparam logic [CMD_BITS-1:0] CMD_POS_AD2 = 6'h3B;
  localparam logic [2:0] CMD_MEM_HI = 3'h5;

  localparam logic [MEM_BITS-1:0] CSET_LEGACY = 16'h0001;
  localparam logic [MEM_BITS-1:0] CSET_EXT = 16'h0002;
  localparam logic [MEM_BITS-1:0] TYPE_INC_LIN = 16'h0000;
  localparam logic [MEM_BITS-1:0] TYPE_ABS_LIN = 16'h0001;
  localparam logic [MEM_BITS-1:0] TYPE_INC_ST = 16'h0002;
  localparam logic [MEM_BITS-1:0] TYPE_ABS_ST = 16'h0003;
  localparam logic [MEM_BITS-1:0] TYPE_MT = 16'h0004;
  localparam logic [MEM_BITS-1:0] TYPE_MT_BAT = 16'h0005;

  localparam logic [MEM_ADDR_W-1:0] MEM_POS_BITS = 3'h0;
  localparam logic [MEM_ADDR_W-1:0] MEM_CSET = 3'h1;
  localparam logic [MEM_ADDR_W-1:0] MEM_TYPE = 3'h2;
  localparam logic [MEM_ADDR_W-1:0] MEM_MAX_KHZ = 3'h3;
  localparam logic [MEM_ADDR_W-1:0] MEM_CAL_REF = 3'h4;
  localparam logic [MEM_ADDR_W-1:0] MEM_T_CAL = 3'h5;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_CMD  = 2'h1,
    E_CALC = 2'h3,
    E_TX   = 2'h2
  } esl_enc_state_type;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_CMD  = 3'h1,
    M_WAIT = 3'h3,
    M_RX   = 3'h2,
    M_TAIL = 3'h6
  } esl_mst_state_type;

  function automatic logic [1:0] esl_add_words(
    input logic [CMD_BITS-1:0] cmd
  );
    logic [1:0] n;
    n = 2'h0;
    if (cmd == CMD_POS_AD1) begin
      n = 2'h1;
    end else if (cmd == CMD_POS_AD2) begin
      n = 2'h2;
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// ===== rtl/esl_link_if.sv
// clock pair and shared data pair between master and encoder
// assumes undriven data reads as low
`default_nettype none
interface esl_link_if;
  logic sclk;
  logic m_dat;
  logic m_dat_oe_n;
  logic e_dat;
  logic e_dat_oe_n;
  logic dat;

  assign dat = !m_dat_oe_n ? m_dat : (!e_dat_oe_n ? e_dat : 1'h0);

  modport master (
    output sclk,
    output m_dat,
    output m_dat_oe_n,
    input  dat
  );
  modport encoder (
    input  sclk,
    input  dat,
    output e_dat,
    output e_dat_oe_n
  );
endinterface
`default_nettype wire

// ===== rtl/esl_fifo.sv
// word fifo with valid/ready on both sides and a fill level
// assumes one clock domain
`default_nettype none
module esl_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [W-1:0]             in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [W-1:0]                  out_data,
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [LW-1:0] cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != LW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rptr_r];
  assign level     = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'h1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'h1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/esl_master.sv
// master end: makes the link clock, sends mode commands, collects words
// assumes the encoder end of esl_link_if on the far side
`default_nettype none
module esl_master
  import esl_pkg::*;
#(
  parameter int POS_BITS    = POS_BITS_DEF,
  parameter int LINK_KHZ    = LINK_MAX_KHZ,
  parameter bit DELAY_COMP  = 1'b0,
  parameter bit INCR_CABLE  = 1'b0,
  parameter int ENC_MAX_KHZ = LINK_MAX_KHZ,
  parameter int WAIT_FALLS  = 64,
  parameter int DEPTH       = FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst,
  esl_link_if.master               link,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic [CMD_BITS-1:0] req_cmd,
  output logic                     rsp_valid,
  input  wire logic                rsp_ready,
  output logic [WORD_W-1:0]        rsp_data,
  output logic                     rsp_timeout,
  output logic                     busy
);
  localparam int CAP_KHZ = (DELAY_COMP && !INCR_CABLE) ?
                           LINK_COMP_MAX_KHZ : LINK_MAX_KHZ;
  localparam int F1 = (LINK_KHZ < CAP_KHZ) ? LINK_KHZ : CAP_KHZ;
  localparam int F2 = (F1 < ENC_MAX_KHZ) ? F1 : ENC_MAX_KHZ;
  localparam int F3 = (F2 > LINK_MIN_KHZ) ? F2 : LINK_MIN_KHZ;
  localparam int HALF_RAW = (CLK_KHZ + 2 * F3 - 1) / (2 * F3);
  localparam int HALF = (HALF_RAW < 1) ? 1 : HALF_RAW;
  localparam int DW = $clog2(HALF + 1);
  localparam int CW = 8;
  localparam int LW = $clog2(DEPTH + 1);

  esl_mst_state_type   state_r;
  logic [DW-1:0]       div_r;
  logic                sclk_r;
  logic                dat_r;
  logic                oe_n_r;
  logic [CMD_BITS-1:0] cmd_r;
  logic [CMD_BITS-1:0] csh_r;
  logic [CW-1:0]       cnt_r;
  logic [1:0]          n_r;
  logic [1:0]          field_r;
  logic [WORD_W-1:0]   sh_r;
  logic [WORD_W-1:0]   sh_nxt;
  logic                push_r;
  logic [WORD_W-1:0]   word_r;
  logic                tmo_r;
  logic                din_s1_r;
  logic                din_s2_r;
  logic                tick;
  logic                fall_tick;
  logic                rise_tick;
  logic                fifo_in_ready;
  logic [LW-1:0]       fifo_level;
  logic                word_end;

  assign tick      = (state_r != M_IDLE) && (div_r == DW'(HALF - 1));
  assign fall_tick = tick & sclk_r;
  assign rise_tick = tick & ~sclk_r;
  assign req_ready = (state_r == M_IDLE) & fifo_in_ready &
                     (fifo_level <= LW'(DEPTH - 1 - MAX_ADD_WORDS));
  assign busy      = (state_r != M_IDLE);
  assign sh_nxt    = {sh_r[WORD_W-2:0], din_s2_r};
  assign word_end  = (field_r == 2'h0) ? (cnt_r == CW'(POS_BITS)) :
                                         (cnt_r == CW'(ADD_BITS - 1));
  assign link.sclk       = sclk_r;
  assign link.m_dat      = dat_r;
  assign link.m_dat_oe_n = oe_n_r;
  assign rsp_timeout     = tmo_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      din_s1_r <= 1'h0;
      din_s2_r <= 1'h0;
    end else begin
      din_s1_r <= link.dat;
      din_s2_r <= din_s1_r;
    end
  end

  // link clock divider, idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r  <= '0;
      sclk_r <= 1'h1;
    end else if (state_r == M_IDLE) begin
      div_r  <= '0;
      sclk_r <= 1'h1;
    end else if (tick) begin
      div_r  <= '0;
      sclk_r <= ~sclk_r;
    end else begin
      div_r <= div_r + 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= M_IDLE;
      dat_r   <= 1'h0;
      oe_n_r  <= 1'h1;
      cmd_r   <= '0;
      csh_r   <= '0;
      cnt_r   <= '0;
      n_r     <= '0;
      field_r <= '0;
      sh_r    <= '0;
      push_r  <= 1'h0;
      word_r  <= '0;
      tmo_r   <= 1'h0;
    end else begin
      push_r <= 1'h0;
      tmo_r  <= 1'h0;
      unique case (state_r)
        M_IDLE: begin
          if (req_valid && req_ready) begin
            cmd_r   <= req_cmd;
            csh_r   <= req_cmd;
            cnt_r   <= '0;
            state_r <= M_CMD;
          end
        end
        M_CMD: begin
          if (fall_tick) begin
            if (cnt_r == CW'(CMD_BITS)) begin
              oe_n_r  <= 1'h1;
              cnt_r   <= '0;
              state_r <= M_WAIT;
            end else begin
              oe_n_r <= 1'h0;
              dat_r  <= csh_r[CMD_BITS-1];
              csh_r  <= {csh_r[CMD_BITS-2:0], 1'h0};
              cnt_r  <= cnt_r + 1'h1;
            end
          end
        end
        M_WAIT: begin
          if (fall_tick) begin
            if (din_s2_r) begin
              cnt_r   <= '0;
              field_r <= '0;
              sh_r    <= '0;
              state_r <= M_RX;
            end else if (cnt_r == CW'(WAIT_FALLS - 1)) begin
              tmo_r   <= 1'h1;
              state_r <= M_TAIL;
            end else begin
              cnt_r <= cnt_r + 1'h1;
            end
          end
        end
        M_RX: begin
          if (fall_tick) begin
            if (field_r == 2'h0 && cnt_r == '0) begin
              n_r <= din_s2_r ? 2'h0 : esl_add_words(cmd_r);
            end
            if (word_end) begin
              push_r  <= fifo_in_ready;
              word_r  <= sh_nxt;
              sh_r    <= '0;
              cnt_r   <= '0;
              field_r <= field_r + 1'h1;
              if (field_r == n_r) begin
                state_r <= M_TAIL;
              end
            end else begin
              sh_r  <= sh_nxt;
              cnt_r <= cnt_r + 1'h1;
            end
          end
        end
        M_TAIL: begin
          if (rise_tick) begin
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  esl_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .in_data   (word_r),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data),
    .level     (fifo_level)
  );
endmodule
`default_nettype wire

// ===== rtl/esl_encoder.sv
// encoder end: takes mode commands and returns position or memory words
// assumes the master end of esl_link_if drives the link clock
//
// How it works
// - shift only on edges of master's clock
// - master sends mode command before any data
// - legacy set flags extended commands as error
// - extended set accepts legacy plus additional data
// - master keeps clock within low and high limit
// - compensated master may reach the top rate
// - maximum clock readable; master never exceeds it
// - incremental cable caps clock at lower maximum
// - reply waits calc time and 14.5 pulses
// - calc time referenced to capped clock rate
// - send only resolution bits, bit count readable
// - position alone or followed by additional data
// - position rises in the marked direction
// - command set identifier held in memory
// - encoder type held in readable memory
// - clock one way, data pair shared both ways
// - selection code picks one or two extra words
`default_nettype none
module esl_encoder
  import esl_pkg::*;
#(
  parameter int                  POS_BITS    = POS_BITS_DEF,
  parameter bit                  EXT_SET     = 1'b1,
  parameter bit                  POS_INVERT  = 1'b0,
  parameter logic [MEM_BITS-1:0] ENC_TYPE    = TYPE_ABS_ST,
  parameter int                  MAX_CLK_KHZ = LINK_MAX_KHZ,
  parameter int                  T_CAL_NS    = 5000,
  parameter int                  IDLE_CYC    = 256
) (
  input  wire logic                clk,
  input  wire logic                rst,
  esl_link_if.encoder              link,
  input  wire logic [POS_BITS-1:0] pos_in,
  input  wire logic [ADD_BITS-1:0] add1_in,
  input  wire logic [ADD_BITS-1:0] add2_in,
  output logic                     frame_busy,
  output logic                     cmd_err,
  output logic [CMD_BITS-1:0]      last_cmd
);
  localparam int TX_W = 2 + POS_BITS + 2 * ADD_BITS;
  localparam int BW = $clog2(TX_W + 1);
  localparam int CAL_RAW = (T_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CYC = (CAL_RAW < 1) ? 1 : CAL_RAW;
  localparam int TW = $clog2(CAL_CYC + 1);
  localparam int EW = $clog2(CAL_HALVES + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int CAL_REF_KHZ = (MAX_CLK_KHZ < CAL_REF_CAP_KHZ) ?
                               MAX_CLK_KHZ : CAL_REF_CAP_KHZ;
  localparam logic [MEM_BITS-1:0] CSET = EXT_SET ? CSET_EXT : CSET_LEGACY;
  localparam logic [BW-1:0] LEN0 = BW'(2 + POS_BITS);
  localparam logic [BW-1:0] LEN1 = BW'(2 + POS_BITS + ADD_BITS);
  localparam logic [BW-1:0] LEN2 = BW'(2 + POS_BITS + 2 * ADD_BITS);

  esl_enc_state_type    state_r;
  logic                 sclk_s1_r;
  logic                 sclk_s2_r;
  logic                 sclk_s3_r;
  logic                 dat_s1_r;
  logic                 dat_s2_r;
  logic                 rise;
  logic                 fall;
  logic [EW-1:0]        ecnt_r;
  logic [TW-1:0]        cal_r;
  logic [IW-1:0]        idle_r;
  logic                 timeout;
  logic [CMD_BITS-1:0]  csh_r;
  logic [CMD_BITS-1:0]  cmd_full;
  logic [BW-1:0]        bidx_r;
  logic [BW-1:0]        len_r;
  logic [TX_W-1:0]      tx_r;
  logic                 oe_n_r;
  logic                 err_r;
  logic                 mem_sel_r;
  logic [MEM_ADDR_W-1:0] addr_r;
  logic [1:0]           n_r;
  logic [POS_BITS-1:0]  pos_r;
  logic [ADD_BITS-1:0]  add1_r;
  logic [ADD_BITS-1:0]  add2_r;
  logic                 dec_err;
  logic                 dec_mem;
  logic [1:0]           dec_n;
  logic [POS_BITS-1:0]  field;
  logic                 cmd_err_r;
  logic [CMD_BITS-1:0]  last_cmd_r;

  function automatic logic [MEM_BITS-1:0] mem_word(
    input logic [MEM_ADDR_W-1:0] a
  );
    logic [MEM_BITS-1:0] w;
    w = '0;
    unique case (a)
      MEM_POS_BITS: w = MEM_BITS'(POS_BITS);
      MEM_CSET:     w = CSET;
      MEM_TYPE:     w = ENC_TYPE;
      MEM_MAX_KHZ:  w = MEM_BITS'(MAX_CLK_KHZ);
      MEM_CAL_REF:  w = MEM_BITS'(CAL_REF_KHZ);
      MEM_T_CAL:    w = MEM_BITS'(T_CAL_NS);
      default:      w = '0;
    endcase
    return w;
  endfunction

  assign rise     = sclk_s2_r & ~sclk_s3_r;
  assign fall     = ~sclk_s2_r & sclk_s3_r;
  assign cmd_full = {csh_r[CMD_BITS-2:0], dat_s2_r};
  assign timeout  = (idle_r == IW'(IDLE_CYC - 1));
  assign field    = mem_sel_r ? POS_BITS'(mem_word(addr_r)) : pos_r;
  assign frame_busy     = (state_r != E_IDLE);
  assign cmd_err        = cmd_err_r;
  assign last_cmd       = last_cmd_r;
  assign link.e_dat     = tx_r[TX_W-1];
  assign link.e_dat_oe_n = oe_n_r;

  // link clock and data sampled through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1_r <= 1'h1;
      sclk_s2_r <= 1'h1;
      sclk_s3_r <= 1'h1;
      dat_s1_r  <= 1'h0;
      dat_s2_r  <= 1'h0;
    end else begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      dat_s1_r  <= link.dat;
      dat_s2_r  <= dat_s1_r;
    end
  end

  // mode command decode
  always_comb begin
    dec_err = 1'h0;
    dec_mem = 1'h0;
    dec_n   = 2'h0;
    if (cmd_full == CMD_POS) begin
      dec_n = 2'h0;
    end else if (cmd_full[CMD_BITS-1 -: 3] == CMD_MEM_HI) begin
      dec_mem = 1'h1;
    end else if (esl_add_words(cmd_full) != 2'h0) begin
      if (EXT_SET) begin
        dec_n = esl_add_words(cmd_full);
      end else begin
        dec_err = 1'h1;
      end
    end else begin
      dec_err = 1'h1;
    end
  end

  // half-period count and calculation timer from frame start
  always_ff @(posedge clk) begin
    if (rst) begin
      ecnt_r <= '0;
      cal_r  <= '0;
    end else if (state_r == E_IDLE) begin
      ecnt_r <= fall ? EW'(1) : '0;
      cal_r  <= '0;
    end else begin
      if ((rise || fall) && ecnt_r != EW'(CAL_HALVES)) begin
        ecnt_r <= ecnt_r + 1'h1;
      end
      if (cal_r != TW'(CAL_CYC)) begin
        cal_r <= cal_r + 1'h1;
      end
    end
  end

  // frame abandoned when the clock rests high too long
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_r <= '0;
    end else if (state_r == E_IDLE || !sclk_s2_r || timeout) begin
      idle_r <= '0;
    end else begin
      idle_r <= idle_r + 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= E_IDLE;
      csh_r      <= '0;
      bidx_r     <= '0;
      len_r      <= '0;
      tx_r       <= '0;
      oe_n_r     <= 1'h1;
      err_r      <= 1'h0;
      mem_sel_r  <= 1'h0;
      addr_r     <= '0;
      n_r        <= '0;
      pos_r      <= '0;
      add1_r     <= '0;
      add2_r     <= '0;
      cmd_err_r  <= 1'h0;
      last_cmd_r <= '0;
    end else begin
      cmd_err_r <= 1'h0;
      if (timeout) begin
        oe_n_r  <= 1'h1;
        state_r <= E_IDLE;
      end else begin
        unique case (state_r)
          E_IDLE: begin
            if (fall) begin
              pos_r   <= POS_INVERT ? ~pos_in : pos_in;
              add1_r  <= add1_in;
              add2_r  <= add2_in;
              bidx_r  <= '0;
              state_r <= E_CMD;
            end
          end
          E_CMD: begin
            if (rise) begin
              csh_r  <= cmd_full;
              bidx_r <= bidx_r + 1'h1;
              if (bidx_r == BW'(CMD_BITS - 1)) begin
                last_cmd_r <= cmd_full;
                err_r      <= dec_err;
                cmd_err_r  <= dec_err;
                mem_sel_r  <= dec_mem;
                addr_r     <= cmd_full[MEM_ADDR_W-1:0];
                n_r        <= dec_n;
                state_r    <= E_CALC;
              end
            end
          end
          E_CALC: begin
            if (fall && ecnt_r >= EW'(CAL_HALVES - 1) &&
                cal_r == TW'(CAL_CYC)) begin
              tx_r    <= {1'h1, err_r, field, add1_r, add2_r};
              unique case (n_r)
                2'h1:    len_r <= LEN1;
                2'h2:    len_r <= LEN2;
                default: len_r <= LEN0;
              endcase
              bidx_r  <= '0;
              oe_n_r  <= 1'h0;
              state_r <= E_TX;
            end
          end
          E_TX: begin
            if (fall) begin
              if (bidx_r == len_r - 1'h1) begin
                oe_n_r  <= 1'h1;
                state_r <= E_IDLE;
              end else begin
                tx_r   <= {tx_r[TX_W-2:0], 1'h0};
                bidx_r <= bidx_r + 1'h1;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/esl_link_checker.sv
// assertions on the link wires between master and encoder
// assumes the bench feeds it the signals of the joining interface
`default_nettype none
module esl_link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic m_dat,
  input wire logic m_dat_oe_n,
  input wire logic e_dat,
  input wire logic e_dat_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] nfall_r;
  logic [7:0] since_r;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // falls counted from the first fall of a frame
  always_ff @(posedge clk) begin
    if (rst) nfall_r <= 8'h00;
    else if ($fell(m_dat_oe_n)) nfall_r <= 8'h01;
    else if ($fell(sclk) && nfall_r != 8'hFF) nfall_r <= nfall_r + 8'h01;
  end

  // cycles since the last link clock fall
  always_ff @(posedge clk) begin
    if (rst || $fell(sclk)) since_r <= 8'h00;
    else if (since_r != 8'hFF) since_r <= since_r + 8'h01;
  end

  chk_no_contention: assert property (m_dat_oe_n || e_dat_oe_n)
    else $error("both ends drive data");
  chk_low_phase: assert property (
    $fell(sclk) |=> (!sclk)[*8] ##1 !sclk)
    else $error("link clock low too short");
  chk_high_phase: assert property (
    $rose(sclk) |=> sclk[*8] ##1 sclk)
    else $error("link clock high too short");
  chk_low_bound: assert property ($fell(sclk) |-> ##[1:200] sclk)
    else $error("link clock below lower limit");
  chk_enc_shift: assert property (
    (!e_dat_oe_n && $changed(e_dat)) |-> since_r <= 8'h06)
    else $error("encoder data moved off clock");
  chk_mst_shift: assert property (
    (!m_dat_oe_n && $changed(m_dat)) |-> $fell(sclk))
    else $error("master data moved off clock");
  chk_start_delay: assert property (
    $fell(e_dat_oe_n) |-> nfall_r >= 8'h0F)
    else $error("reply started too early");
  chk_start_one: assert property ($fell(e_dat_oe_n) |-> e_dat)
    else $error("reply without start bit");
  chk_cmd_release: assert property (
    $rose(m_dat_oe_n) |-> $fell(sclk) && nfall_r == 8'h06)
    else $error("master kept data after command");
  chk_cmd_first: assert property ($fell(m_dat_oe_n) |-> $fell(sclk))
    else $error("command not on first fall");
endmodule
`default_nettype wire

// ===== test/encoder_serial_position_link_test.sv
// bench: master and encoder back to back, plus a legacy pair
// assumes the design files and the link checker are compiled first
`default_nettype none
module encoder_serial_position_link_test;
  import esl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [1:0]            rv = 2'h0;
  logic [1:0]            rr = 2'h0;
  logic [CMD_BITS-1:0]   cmd = 6'h00;
  logic [POS_BITS_DEF-1:0] pos = 24'h12_3456;
  logic [ADD_BITS-1:0]   ad1 = 16'hA5C3;
  logic [ADD_BITS-1:0]   ad2 = 16'h3C5A;
  logic                  seen_err = 1'b0;
  logic                  seen_tmo = 1'b0;
  wire [1:0]             rdy, vld, bsy;
  wire [1:0]             fbsy, tmo;
  wire                   cerr_b;
  wire [CMD_BITS-1:0]    lcmd_b;
  wire [WORD_W-1:0]      rdat [2];
  int                    fail_count = 0;
  int                    total_checks = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (cerr_b === 1'b1) seen_err <= 1'b1;
  always @(posedge clk) if ((|tmo) === 1'b1) seen_tmo <= 1'b1;

  esl_link_if u_esl_link_if ();
  esl_link_if u_esl_link_if_b ();
  esl_master u_esl_master (.clk(clk), .rst(rst), .link(u_esl_link_if),
    .req_valid(rv[0]), .req_ready(rdy[0]), .req_cmd(cmd), .rsp_valid(vld[0]),
    .rsp_ready(rr[0]), .rsp_data(rdat[0]), .rsp_timeout(tmo[0]),
    .busy(bsy[0]));
  esl_encoder #(.ENC_TYPE(TYPE_MT_BAT), .T_CAL_NS(100)) u_esl_encoder (
    .clk(clk), .rst(rst), .link(u_esl_link_if), .pos_in(pos),
    .add1_in(ad1), .add2_in(ad2), .frame_busy(fbsy[0]), .cmd_err(),
    .last_cmd());
  esl_master u_esl_master_b (.clk(clk), .rst(rst), .link(u_esl_link_if_b),
    .req_valid(rv[1]), .req_ready(rdy[1]), .req_cmd(cmd), .rsp_valid(vld[1]),
    .rsp_ready(rr[1]), .rsp_data(rdat[1]), .rsp_timeout(tmo[1]),
    .busy(bsy[1]));
  esl_encoder #(.EXT_SET(1'b0), .T_CAL_NS(100)) u_esl_encoder_b (
    .clk(clk), .rst(rst), .link(u_esl_link_if_b), .pos_in(pos),
    .add1_in(ad1), .add2_in(ad2), .frame_busy(fbsy[1]), .cmd_err(cerr_b),
    .last_cmd(lcmd_b));
  esl_link_checker u_esl_link_checker (.clk(clk), .rst(rst),
    .sclk(u_esl_link_if.sclk), .m_dat(u_esl_link_if.m_dat),
    .m_dat_oe_n(u_esl_link_if.m_dat_oe_n), .e_dat(u_esl_link_if.e_dat),
    .e_dat_oe_n(u_esl_link_if.e_dat_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic give_up();
    fail_count++;
    $display("[FAIL] %0t ns wait ran out", $time);
    summarize();
  endtask

  // one mode command, held until taken, then wait for frame end
  task automatic run(input int b, input logic [CMD_BITS-1:0] c);
    int n;
    n = 0;
    @(posedge clk);
    cmd <= c;
    rv[b] <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 4000) give_up();
    end while (rdy[b] !== 1'b1);
    @(posedge clk);
    rv[b] <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      if (++n > 8000) give_up();
    end while (bsy[b] !== 1'b0);
  endtask

  task automatic pop(input int b, input logic [31:0] exp);
    @(negedge clk);
    check({31'h0, vld[b]}, 32'h1);
    check(rdat[b], exp);
    @(posedge clk);
    rr[b] <= 1'b1;
    @(posedge clk);
    rr[b] <= 1'b0;
  endtask

  task automatic empty(input int b);
    @(negedge clk);
    check({31'h0, vld[b]}, 32'h0);
  endtask

  task automatic t_reset();
    @(negedge clk);
    check({24'h0, fbsy, u_esl_link_if.sclk, u_esl_link_if.m_dat_oe_n,
      u_esl_link_if.e_dat_oe_n, rdy[0], vld[0], bsy[0]}, 32'h3C);
    $display("reset test done");
  endtask

  task automatic t_pos();
    run(0, CMD_POS);
    pop(0, {8'h00, pos});
    empty(0);
    @(posedge clk);
    pos <= pos + 24'h00_0001;
    run(0, CMD_POS);
    pop(0, {8'h00, 24'h12_3457});
    run(0, CMD_POS_AD1);
    pop(0, {8'h00, 24'h12_3457});
    pop(0, {16'h0000, ad1});
    empty(0);
    run(0, 6'h00);
    pop(0, {7'h00, 1'b1, 24'h12_3457});
    empty(0);
    $display("position test done");
  endtask

  task automatic t_mem();
    logic [MEM_BITS-1:0] m [6];
    m = '{16'h0018, CSET_EXT, TYPE_MT_BAT, 16'h07D0, 16'h07D0, 16'h0064};
    for (int a = 0; a < 6; a++) begin
      run(0, {CMD_MEM_HI, 3'(a)});
      pop(0, {16'h0000, m[a]});
    end
    $display("memory test done");
  endtask

  task automatic t_legacy();
    logic [CMD_BITS-1:0] c [3];
    c = '{CMD_POS_AD1, CMD_POS_AD2, 6'h00};
    for (int i = 0; i < 3; i++) begin
      seen_err = 1'b0;
      run(1, c[i]);
      check({31'h0, seen_err}, 32'h1);
      check({26'h0, lcmd_b}, {26'h0, c[i]});
      pop(1, {7'h00, 1'b1, 24'h12_3457});
      empty(1);
    end
    run(1, CMD_POS);
    pop(1, {8'h00, 24'h12_3457});
    run(1, {CMD_MEM_HI, MEM_CSET});
    pop(1, {16'h0000, CSET_LEGACY});
    $display("legacy test done");
  endtask

  task automatic t_fifo();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      pos <= 24'h00_0100 + 24'(i);
      run(0, CMD_POS_AD2);
    end
    @(negedge clk);
    check({31'h0, rdy[0]}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pop(0, {8'h00, 24'h00_0100 + 24'(i)});
      pop(0, {16'h0000, ad1});
      pop(0, {16'h0000, ad2});
    end
    empty(0);
    check({31'h0, seen_tmo}, 32'h0);
    $display("buffer test done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_pos();
    t_mem();
    t_legacy();
    t_fifo();
    summarize();
  end
endmodule
`default_nettype wire
